// File: design/unbfb_pkg.sv
/*
  Shared constants for the fixed-rate nine-bit serial port: bit-rate
  divisors, oversampling, frame layout, reset values and state encodings.
  Assumes a single core clock with a synchronous active-high reset.
*/
package unbfb_pkg;

  // Bit-rate divisors of the core clock
  localparam int unsigned DIV_SLOW        = 64;
  localparam int unsigned DIV_FAST        = 32;
  // Sub-bit ticks per bit period
  localparam int unsigned OVERSAMPLE      = 16;
  localparam int unsigned TICK_DIV_SLOW   = DIV_SLOW / OVERSAMPLE;
  localparam int unsigned TICK_DIV_FAST   = DIV_FAST / OVERSAMPLE;
  // Tick within a bit at which the receiver samples
  localparam logic [3:0]  SAMPLE_TICK     = 4'h7;
  localparam logic [3:0]  LAST_TICK       = 4'hf;

  // Frame layout: index of each bit slot
  localparam int unsigned DATA_BITS       = 8;
  localparam logic [3:0]  SLOT_START      = 4'h0;
  localparam logic [3:0]  SLOT_DATA_LAST  = 4'h8;
  localparam logic [3:0]  SLOT_NINTH      = 4'h9;
  localparam logic [3:0]  SLOT_STOP       = 4'ha;

  // Reset values
  localparam logic        BAUD_DOUBLE_RST = 1'b0;
  localparam logic        LINE_IDLE       = 1'b1;

  typedef enum logic [1:0] {
    TX_IDLE,
    TX_ALIGN,
    TX_SHIFT
  } unbfb_tx_state_t;

  typedef enum logic [0:0] {
    RX_IDLE,
    RX_FRAME
  } unbfb_rx_state_t;

endpackage : unbfb_pkg

// File: design/unbfb_baud_tick.sv
/*
  Oversampling tick generator: one-cycle enable pulse every TICK_DIV_SLOW
  core cycles, or every TICK_DIV_FAST when the double-rate bit is set.
  Assumes the select is a same-clock registered level.
*/
module unbfb_baud_tick
  import unbfb_pkg::*;
#(
  parameter int unsigned DIV_LOW  = TICK_DIV_SLOW,
  parameter int unsigned DIV_HIGH = TICK_DIV_FAST
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Rate select
  input  wire logic baud_double,
  // Oversample enable
  output logic      tick
);

  localparam int unsigned CW = $clog2(DIV_LOW);

  initial begin
    if (DIV_HIGH < 1 || DIV_LOW < 2 || DIV_HIGH > DIV_LOW) begin
      $error("unbfb_baud_tick: divisors out of range");
    end
  end

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } unbfb_div_state_t;

  unbfb_div_state_t state_ff;
  unbfb_div_state_t nxt_state;

  logic [CW-1:0] limit;

  always_comb begin
    limit     = baud_double ? CW'(DIV_HIGH - 1) : CW'(DIV_LOW - 1);
    nxt_state = state_ff;
    nxt_state.tick = 1'b0;
    if (state_ff.cnt >= limit) begin
      nxt_state.cnt  = '0;
      nxt_state.tick = 1'b1;
    end else begin
      nxt_state.cnt = state_ff.cnt + CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign tick = state_ff.tick;

endmodule : unbfb_baud_tick

// File: design/unbfb_uart.sv
/*
  Full-duplex nine-bit asynchronous serial port at a fixed fraction of the
  core clock. Control and status bits are plain ports; software-side
  strobes are one-cycle pulses on MCLK. The receive pin is asynchronous.
*/
// How it works
// - Frames are start, eight data bits LSB first, ninth bit, stop; both directions concurrent.
// - Transmitted ninth bit is the live transmit ninth-bit control value.
// - Received ninth bit goes to the ninth-bit status; stop bit value ignored.
// - Writing a byte to the serial buffer while the transmitter is idle starts a new frame.
// - Transmit-done flag sets as the stop bit begins.
// - Receiver only starts frames while receive enable is 1.
// - Frame accepted only if receive-done is 0 and filter passes ninth bit 1.
// - Accepted frame loads receive buffer and ninth bit, and sets receive-done.
// - Rejected frame leaves buffer, ninth bit and receive-done untouched.
// - Serial interrupt requested while either done flag is set and enabled.
// - Bit rate is core clock over 64, or over 32 with baud double.
// - Baud double resets to 0, selecting the slower rate.
module unbfb_uart
  import unbfb_pkg::*;
(
  // Clock and reset
  input  wire logic       MCLK,
  input  wire logic       RESET,
  // Serial buffer write
  input  wire logic       SERIAL_BUFFER_WR,
  input  wire logic [7:0] SERIAL_BUFFER_WDATA,
  // Control levels
  input  wire logic       TX_NINTH_BIT,
  input  wire logic       RX_ENABLE,
  input  wire logic       MULTIPROC_FILTER,
  input  wire logic       IRQ_ENABLE,
  // Baud double control
  input  wire logic       BAUD_DOUBLE_WR,
  input  wire logic       BAUD_DOUBLE_WDATA,
  output logic            BAUD_DOUBLE,
  // Flag clears
  input  wire logic       TX_DONE_CLR,
  input  wire logic       RX_DONE_CLR,
  // Status
  output logic            TX_DONE_FLAG,
  output logic            RX_DONE_FLAG,
  output logic [7:0]      RX_BUFFER,
  output logic            RX_NINTH_BIT,
  output logic            TX_BUSY,
  output logic            RX_BUSY,
  output logic            SERIAL_IRQ,
  // Serial pins
  output logic            TXD,
  input  wire logic       RXD
);

  typedef struct packed {
    // Configuration
    logic                 baud_double;
    // Transmitter
    unbfb_tx_state_t      tx_state;
    logic [DATA_BITS-1:0] tx_shift;
    logic [3:0]           tx_slot;
    logic [3:0]           tx_tick;
    logic                 txd;
    logic                 tx_done;
    // Receive pin conditioning
    logic [2:0]           rx_sync;
    logic                 rx_level;
    // Receiver
    unbfb_rx_state_t      rx_state;
    logic [3:0]           rx_slot;
    logic [3:0]           rx_tick;
    logic [DATA_BITS-1:0] rx_shift;
    logic                 rx_ninth_new;
    logic [DATA_BITS-1:0] rx_buffer;
    logic                 rx_ninth;
    logic                 rx_done;
  } unbfb_state_t;

  localparam unbfb_state_t STATE_RST = '{
    baud_double:  BAUD_DOUBLE_RST,
    tx_state:     TX_IDLE,
    tx_shift:     '0,
    tx_slot:      '0,
    tx_tick:      '0,
    txd:          LINE_IDLE,
    tx_done:      1'b0,
    rx_sync:      {3{LINE_IDLE}},
    rx_level:     LINE_IDLE,
    rx_state:     RX_IDLE,
    rx_slot:      '0,
    rx_tick:      '0,
    rx_shift:     '0,
    rx_ninth_new: 1'b0,
    rx_buffer:    '0,
    rx_ninth:     1'b0,
    rx_done:      1'b0
  };

  unbfb_state_t state_ff;
  unbfb_state_t nxt_state;

  logic tick;
  logic tx_done_set;
  logic rx_done_set;
  logic rx_level_now;
  logic rx_accept;

  // Both directions share one oversample reference
  unbfb_baud_tick #(
    .DIV_LOW  (TICK_DIV_SLOW),
    .DIV_HIGH (TICK_DIV_FAST)
  ) u_tick (
    .clk         (MCLK),
    .rst         (RESET),
    .baud_double (state_ff.baud_double),
    .tick        (tick)
  );

  // Sync stage 0 feeds only stage 1; the level moves once stages 1 and 2 agree
  function automatic logic filtered_level(input logic [2:0] sync, input logic prev);
    filtered_level = (sync[1] == sync[2]) ? sync[2] : prev;
  endfunction : filtered_level

  always_comb begin
    nxt_state    = state_ff;
    tx_done_set  = 1'b0;
    rx_done_set  = 1'b0;
    rx_accept    = 1'b0;

    if (BAUD_DOUBLE_WR) begin
      nxt_state.baud_double = BAUD_DOUBLE_WDATA;
    end

    // Transmitter
    unique case (state_ff.tx_state)
      TX_IDLE: begin
        // Writes while a frame is in flight are dropped, never corrupt the line
        if (SERIAL_BUFFER_WR) begin
          nxt_state.tx_shift = SERIAL_BUFFER_WDATA;
          nxt_state.tx_state = TX_ALIGN;
        end
      end
      TX_ALIGN: begin
        // Start bit begins on a tick so every slot is a whole bit period
        if (tick) begin
          nxt_state.txd      = 1'b0;
          nxt_state.tx_slot  = SLOT_START;
          nxt_state.tx_tick  = '0;
          nxt_state.tx_state = TX_SHIFT;
        end
      end
      TX_SHIFT: begin
        if (tick) begin
          nxt_state.tx_tick = state_ff.tx_tick + 4'h1;
          if (state_ff.tx_tick == LAST_TICK) begin
            nxt_state.tx_slot = state_ff.tx_slot + 4'h1;
            if (state_ff.tx_slot < SLOT_DATA_LAST) begin
              // LSB first
              nxt_state.txd      = state_ff.tx_shift[0];
              nxt_state.tx_shift = {1'b0, state_ff.tx_shift[DATA_BITS-1:1]};
            end else if (state_ff.tx_slot == SLOT_DATA_LAST) begin
              nxt_state.txd = TX_NINTH_BIT;
            end else if (state_ff.tx_slot == SLOT_NINTH) begin
              nxt_state.txd = LINE_IDLE;
              tx_done_set   = 1'b1;
            end else begin
              nxt_state.tx_state = TX_IDLE;
            end
          end
        end
      end
      default: begin
        nxt_state.tx_state = TX_IDLE;
        nxt_state.txd      = LINE_IDLE;
      end
    endcase

    // Receive pin conditioning
    nxt_state.rx_sync  = {state_ff.rx_sync[1:0], RXD};
    rx_level_now       = filtered_level(state_ff.rx_sync, state_ff.rx_level);
    nxt_state.rx_level = rx_level_now;

    // Receiver, independent of the transmitter
    unique case (state_ff.rx_state)
      RX_IDLE: begin
        if (RX_ENABLE && state_ff.rx_level && !rx_level_now) begin
          nxt_state.rx_state = RX_FRAME;
          nxt_state.rx_slot  = SLOT_START;
          nxt_state.rx_tick  = '0;
        end
      end
      RX_FRAME: begin
        if (tick) begin
          nxt_state.rx_tick = state_ff.rx_tick + 4'h1;
          if (state_ff.rx_tick == SAMPLE_TICK) begin
            if (state_ff.rx_slot == SLOT_START) begin
              // A start bit gone high by mid-bit was a glitch
              if (state_ff.rx_level) begin
                nxt_state.rx_state = RX_IDLE;
              end
            end else if (state_ff.rx_slot <= SLOT_DATA_LAST) begin
              nxt_state.rx_shift = {state_ff.rx_level, state_ff.rx_shift[DATA_BITS-1:1]};
            end else if (state_ff.rx_slot == SLOT_NINTH) begin
              nxt_state.rx_ninth_new = state_ff.rx_level;
            end else begin
              // Stop slot: its level is not checked
              nxt_state.rx_state = RX_IDLE;
              rx_accept = !state_ff.rx_done &&
                          (!MULTIPROC_FILTER || state_ff.rx_ninth_new);
              if (rx_accept) begin
                nxt_state.rx_buffer = state_ff.rx_shift;
                nxt_state.rx_ninth  = state_ff.rx_ninth_new;
                rx_done_set         = 1'b1;
              end
              // Otherwise buffer, ninth bit and flag hold their values
            end
          end
          if (state_ff.rx_tick == LAST_TICK) begin
            nxt_state.rx_slot = state_ff.rx_slot + 4'h1;
          end
        end
      end
      default: begin
        nxt_state.rx_state = RX_IDLE;
      end
    endcase

    // A set in the same cycle as a clear wins
    nxt_state.tx_done = tx_done_set | (state_ff.tx_done & ~TX_DONE_CLR);
    nxt_state.rx_done = rx_done_set | (state_ff.rx_done & ~RX_DONE_CLR);
  end

  always_ff @(posedge MCLK) begin
    if (RESET) begin
      state_ff <= STATE_RST;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign TXD          = state_ff.txd;
  assign TX_DONE_FLAG = state_ff.tx_done;
  assign RX_DONE_FLAG = state_ff.rx_done;
  assign RX_BUFFER    = state_ff.rx_buffer;
  assign RX_NINTH_BIT = state_ff.rx_ninth;
  assign BAUD_DOUBLE  = state_ff.baud_double;
  assign TX_BUSY      = (state_ff.tx_state != TX_IDLE);
  assign RX_BUSY      = (state_ff.rx_state != RX_IDLE);
  // Level request; software clears the flag to drop it
  assign SERIAL_IRQ   = IRQ_ENABLE & (state_ff.tx_done | state_ff.rx_done);

endmodule : unbfb_uart

// File: dv/unbfb_checker.sv
/*
  Concurrent checks on the nine-bit serial port pins and flags.
  Bound into unbfb_uart; sees only its ports.
*/
module unbfb_checker (
  // Clock and reset
  input wire logic       MCLK,
  input wire logic       RESET,
  // Control levels
  input wire logic       RX_ENABLE,
  input wire logic       MULTIPROC_FILTER,
  input wire logic       IRQ_ENABLE,
  input wire logic       RX_DONE_CLR,
  // Status and pins
  input wire logic       BAUD_DOUBLE,
  input wire logic       TX_DONE_FLAG,
  input wire logic       RX_DONE_FLAG,
  input wire logic [7:0] RX_BUFFER,
  input wire logic       RX_NINTH_BIT,
  input wire logic       TX_BUSY,
  input wire logic       RX_BUSY,
  input wire logic       SERIAL_IRQ,
  input wire logic       TXD
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  a_irq_level: assert property (SERIAL_IRQ == (IRQ_ENABLE && (TX_DONE_FLAG || RX_DONE_FLAG)))
    else $error("irq level wrong");
  a_reset_state: assert property ($past(RESET) |-> !BAUD_DOUBLE && !TX_DONE_FLAG && !RX_DONE_FLAG)
    else $error("state after reset wrong");
  a_tx_start: assert property ($rose(TX_BUSY) |-> ##[0:5] !TXD)
    else $error("no start bit after write");
  a_tx_stop: assert property ($rose(TX_DONE_FLAG) |-> (TXD && TX_BUSY) [*8])
    else $error("done flag not at stop bit");
  a_tx_idle: assert property (!TX_BUSY |-> TXD)
    else $error("line low while idle");
  a_rx_enable: assert property (!RX_ENABLE && !RX_BUSY |=> !RX_BUSY)
    else $error("frame started while disabled");
  a_rx_load: assert property ($changed(RX_BUFFER) || $changed(RX_NINTH_BIT) |-> $rose(RX_DONE_FLAG))
    else $error("buffer changed without accept");
  a_rx_accept: assert property ($rose(RX_DONE_FLAG) |-> $fell(RX_BUSY))
    else $error("accept not at stop sample");
  a_rx_filter: assert property ($rose(RX_DONE_FLAG) && $past(MULTIPROC_FILTER) |-> RX_NINTH_BIT)
    else $error("filter let ninth bit 0 in");
  a_rx_full: assert property (RX_DONE_FLAG && !RX_DONE_CLR |=> $stable(RX_BUFFER))
    else $error("buffer overwritten while full");
endmodule : unbfb_checker

// File: dv/unbfb_remote.sv
/*
  Remote serial node: sends frames on the receive pin, decodes the
  transmit pin mid-bit. The bench sets the bit period in core cycles.
*/
module unbfb_remote (
  // Clock and bit period
  input  wire logic       clk,
  input  wire logic [6:0] per,
  // Serial pins
  input  wire logic       txd,
  output logic            rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] got;
  int         got_cnt;
  initial begin
    rxd = 1'b1;
    got = '0;
    got_cnt = 0;
  end
  task automatic gap(input int n);
    repeat (n) @(posedge clk);
  endtask : gap
  // Start, data LSB first, ninth, stop; a bad stop is allowed on request
  task automatic send(input logic [8:0] f, input logic stop);
    logic [10:0] w;
    w = {stop, f, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= w[i];
      gap(per);
    end
    rxd <= 1'b1;
    gap(per);
  endtask : send
  always begin
    @(negedge txd);
    gap(per / 2);
    for (int i = 0; i < 10; i++) begin
      gap(per);
      if (i < 9) got[i] = txd;
    end
    got_cnt++;
  end
endmodule : unbfb_remote

// File: dv/tb_unbfb_uart.sv
/*
  Self-checking bench for unbfb_uart against a remote serial node.
  Assumes the remote decodes the transmit pin at the bench's bit period.
*/
module tb_unbfb_uart
  import unbfb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic       MCLK, RESET, SERIAL_BUFFER_WR, TX_NINTH_BIT, RX_ENABLE, MULTIPROC_FILTER, IRQ_ENABLE;
  logic       BAUD_DOUBLE_WR, BAUD_DOUBLE_WDATA, BAUD_DOUBLE, TX_DONE_CLR, RX_DONE_CLR;
  logic       TX_DONE_FLAG, RX_DONE_FLAG, RX_NINTH_BIT, TX_BUSY, RX_BUSY, SERIAL_IRQ, TXD, RXD;
  logic [7:0] SERIAL_BUFFER_WDATA, RX_BUFFER;
  logic [6:0] per;
  int         bad_count, n_tests;
  unbfb_uart unbfb_uart_i (.*);
  unbfb_remote unbfb_remote_i (.clk(MCLK), .per(per), .txd(TXD), .rxd(RXD));
  initial begin
    MCLK = 1'b0;
    forever #2 MCLK = ~MCLK;
  end
  task automatic step(input int n);
    repeat (n) @(posedge MCLK);
    #1;
  endtask : step
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic write(input logic [7:0] d, input logic n);
    @(posedge MCLK);
    SERIAL_BUFFER_WR <= 1'b1;
    SERIAL_BUFFER_WDATA <= d;
    TX_NINTH_BIT <= n;
    @(posedge MCLK);
    SERIAL_BUFFER_WR <= 1'b0;
  endtask : write
  task automatic clr;
    @(posedge MCLK);
    {TX_DONE_CLR, RX_DONE_CLR} <= 2'h3;
    @(posedge MCLK);
    {TX_DONE_CLR, RX_DONE_CLR} <= 2'h0;
    step(1);
  endtask : clr
  task automatic baud(input logic b);
    @(posedge MCLK);
    BAUD_DOUBLE_WR <= 1'b1;
    BAUD_DOUBLE_WDATA <= b;
    per = b ? 7'(DIV_FAST) : 7'(DIV_SLOW);
    @(posedge MCLK);
    BAUD_DOUBLE_WR <= 1'b0;
    step(1);
  endtask : baud
  task automatic tx_frame(input logic [7:0] d, input logic n);
    int k, c;
    c = unbfb_remote_i.got_cnt;
    write(d, n);
    @(negedge TXD);
    k = 0;
    while (TX_DONE_FLAG !== 1'b1 && k < 2000) begin
      step(1);
      k++;
    end
    chk(11'(k), 11'(10 * per));
    write(~d, ~n);
    for (k = 0; TX_BUSY !== 1'b0 && k < 200; k++) step(1);
    step(per);
    chk({2'h0, unbfb_remote_i.got}, {2'h0, n, d});
    chk(11'(unbfb_remote_i.got_cnt - c), 11'h1);
  endtask : tx_frame
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    {RESET, SERIAL_BUFFER_WR, TX_NINTH_BIT, RX_ENABLE, MULTIPROC_FILTER, IRQ_ENABLE} = 6'h20;
    {BAUD_DOUBLE_WR, BAUD_DOUBLE_WDATA, TX_DONE_CLR, RX_DONE_CLR} = 4'h0;
    SERIAL_BUFFER_WDATA = 8'h00;
    per = 7'(DIV_SLOW);
    repeat (12) @(posedge MCLK);
    RESET <= 1'b0;
    step(1);
    chk({TX_DONE_FLAG, RX_DONE_FLAG, BAUD_DOUBLE}, 11'h0);
    unbfb_remote_i.send(9'h155, 1'b1);
    chk({RX_DONE_FLAG, RX_BUFFER}, 11'h0);
    @(posedge MCLK) RX_ENABLE <= 1'b1;
    // Stop bit sent low on purpose: it must not matter
    unbfb_remote_i.send(9'h0a5, 1'b0);
    chk({RX_DONE_FLAG, RX_NINTH_BIT, RX_BUFFER}, 11'h2a5);
    unbfb_remote_i.send(9'h1c3, 1'b1);
    chk({RX_DONE_FLAG, RX_NINTH_BIT, RX_BUFFER}, 11'h2a5);
    clr();
    @(posedge MCLK) MULTIPROC_FILTER <= 1'b1;
    unbfb_remote_i.send(9'h03c, 1'b1);
    chk({RX_DONE_FLAG, RX_NINTH_BIT, RX_BUFFER}, 11'h0a5);
    unbfb_remote_i.send(9'h1e1, 1'b1);
    chk({RX_DONE_FLAG, RX_NINTH_BIT, RX_BUFFER}, 11'h3e1);
    @(posedge MCLK) IRQ_ENABLE <= 1'b1;
    step(1);
    chk(SERIAL_IRQ, 11'h1);
    clr();
    chk(SERIAL_IRQ, 11'h0);
    @(posedge MCLK) MULTIPROC_FILTER <= 1'b0;
    for (int b = 0; b < 2; b++) begin
      baud(b[0]);
      chk(BAUD_DOUBLE, 11'(b));
      // Both directions at once
      fork
        tx_frame(8'h5a ^ 8'(b), b[0]);
        unbfb_remote_i.send({~b[0], 8'h96}, 1'b1);
      join
      chk({RX_NINTH_BIT, RX_BUFFER}, {2'h0, ~b[0], 8'h96});
      clr();
    end
    report_and_stop();
  end
  // Whole run is near 5000 cycles; allow about eight times that
  initial begin
    repeat (40000) @(posedge MCLK);
    bad_count++;
    report_and_stop();
  end
endmodule : tb_unbfb_uart

bind unbfb_uart unbfb_checker unbfb_checker_i (.MCLK(MCLK), .RESET(RESET), .RX_ENABLE(RX_ENABLE),
  .MULTIPROC_FILTER(MULTIPROC_FILTER), .IRQ_ENABLE(IRQ_ENABLE), .RX_DONE_CLR(RX_DONE_CLR),
  .BAUD_DOUBLE(BAUD_DOUBLE), .TX_DONE_FLAG(TX_DONE_FLAG), .RX_DONE_FLAG(RX_DONE_FLAG),
  .RX_BUFFER(RX_BUFFER), .RX_NINTH_BIT(RX_NINTH_BIT), .TX_BUSY(TX_BUSY), .RX_BUSY(RX_BUSY),
  .SERIAL_IRQ(SERIAL_IRQ), .TXD(TXD));
